// ===== design/udt_consts.vh
// Constants shared by the up/down reload timer design files
`ifndef UDT_CONSTS_VH
`define UDT_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UDT_OFS_CTRL 8'h00
`define UDT_OFS_MODE 8'h04
`define UDT_OFS_COUNT 8'h08
`define UDT_OFS_RELOAD 8'h0C
`define UDT_OFS_STAT 8'h10
`define UDT_OFS_MASK 8'h14

// ----------------------------------------------------------------
// Timer control register fields
// ----------------------------------------------------------------
`define UDT_CTL_OVF 7
`define UDT_CTL_EXT 6
`define UDT_CTL_RCLK 5
`define UDT_CTL_TRANSMIT_CLOCK_SELECT 4
`define UDT_CTL_EXEN 3
`define UDT_CTL_RUN 2
`define UDT_CTL_CSEL 1
`define UDT_CTL_CPRL 0

// ----------------------------------------------------------------
// Mode control, status and mask fields
// ----------------------------------------------------------------
`define UDT_MOD_DOWN_COUNT_ENABLE 0
`define UDT_ST_OVF 0
`define UDT_ST_EXT 1
`define UDT_ST_W 2
`define UDT_CNT_EXT 16

// ----------------------------------------------------------------
// Reset values and count constants
// ----------------------------------------------------------------
`define UDT_RST_BYTE 8'h00
`define UDT_RST_WORD 16'h0000
`define UDT_RST_ST 2'h0
`define UDT_BYTE_MAX 8'hFF
`define UDT_WORD_MAX 16'hFFFF
`define UDT_CLK_DIV 12

`endif

// ===== design/udt_pin_sync.v
// Two-flop synchroniser with falling edge detect for external pins
`timescale 1ns/10ps
`default_nettype none

module udt_pin_sync #(
  parameter W = 2
) (
  input wire clk_sys, // System clock
  input wire rstSync_n, // Synchronised reset, active low
  input wire [W-1:0] pinIn, // Raw pin levels
  output reg [W-1:0] level_r, // Synchronised levels
  output wire [W-1:0] fallPulse // One-cycle falling edge pulses
);

  reg [W-1:0] meta_r;
  reg [W-1:0] prev_r;

  // First stage feeds only the second stage
  always @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      meta_r <= {W{1'b1}};
      level_r <= {W{1'b1}};
      prev_r <= {W{1'b1}};
    end else begin
      meta_r <= pinIn;
      level_r <= meta_r;
      prev_r <= level_r;
    end
  end

  assign fallPulse = prev_r & ~level_r;

endmodule
`default_nettype wire

// ===== design/udt_prescale.v
// Internal clock divider producing one tick every DIV cycles
`timescale 1ns/10ps
`default_nettype none
`include "udt_consts.vh"

module udt_prescale #(
  parameter DIV = `UDT_CLK_DIV
) (
  input wire clk_sys, // System clock
  input wire rstSync_n, // Synchronised reset, active low
  output reg tick_r // One-cycle tick every DIV cycles
);

  reg [7:0] div_r;
  wire [7:0] divLast;

  assign divLast = DIV[7:0] - 8'h01;

  always @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      div_r <= `UDT_RST_BYTE;
      tick_r <= 1'b0;
    end else if (div_r == divLast) begin
      div_r <= `UDT_RST_BYTE;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 8'h01;
      tick_r <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== design/udt_timer.v
// 16-bit up/down auto-reload timer/counter with Wishbone slave
//
// How it works
// - Count is a low byte cascaded into a high byte by carry.
// - Counter-select clear counts clock divided by 12; set counts count pin.
// - Low byte advances only while run control bit is set.
// - Capture, auto-reload, baud modes chosen by rclk, transmit_clock_select, capture select.
// - Auto-reload with down-count enable clear counts up only.
// - In auto-reload with down-count enable set, direction pin high counts up, low down.
// - Up count passing FFFFh sets overflow flag, raising interrupt only while mask bit 0 is set.
// - Up overflow loads the reload register into the count in auto-reload mode; in capture mode it loads 0000h.
// - Down count underflows when count equals reload value.
// - Underflow sets overflow flag and loads FFFFh.
// - Up/down mode toggles external flag on wrap, never interrupting from it.
// - External flag reads as count bit 16, a 17th bit.
// - Overflow flag sets only with rclk and transmit_clock_select clear; sticky.
// - Counter mode advances on each falling edge of count pin.
// - Rclk or transmit_clock_select set forces auto-reload, ignoring capture select.
// - Down-count enable is bit 0 of the mode control register.
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "udt_consts.vh"

module udt_timer (
  input wire clk_sys, // System clock, 100 MHz
  input wire arst_n, // Asynchronous reset, active low
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [7:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  input wire count_input_pin, // External count input
  input wire direction_pin, // External direction input
  output reg irq_o // Level interrupt, active high
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  reg rstMeta_r;
  reg rstSync_n;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [7:0] count_low_byte_r;
  reg [7:0] count_high_byte_r;
  reg [7:0] reload_low_byte_r;
  reg [7:0] reload_high_byte_r;
  reg [7:0] ctrl_r;
  reg down_count_enable_r;
  reg [`UDT_ST_W-1:0] stat_r;
  reg [`UDT_ST_W-1:0] mask_r;

  // ----------------------------------------------------------------
  // Pin synchronisers and prescaler
  // ----------------------------------------------------------------
  wire [1:0] pinLevel;
  wire [1:0] pinFall;
  wire divTick;

  udt_pin_sync #(
    .W(2)
  ) uPins (
    .clk_sys(clk_sys),
    .rstSync_n(rstSync_n),
    .pinIn({direction_pin, count_input_pin}),
    .level_r(pinLevel),
    .fallPulse(pinFall)
  );

  udt_prescale #(
    .DIV(`UDT_CLK_DIV)
  ) uDiv (
    .clk_sys(clk_sys),
    .rstSync_n(rstSync_n),
    .tick_r(divTick)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire runOn;
  wire counterSel;
  wire baudMode;
  wire reloadMode;
  wire upDownMode;
  wire countUp;
  wire srcTick;
  wire step;
  wire dirHigh;
  wire dirFall;
  wire [15:0] countWord;
  wire [15:0] reloadWord;

  assign runOn = ctrl_r[`UDT_CTL_RUN];
  assign counterSel = ctrl_r[`UDT_CTL_CSEL];
  assign baudMode = ctrl_r[`UDT_CTL_RCLK] | ctrl_r[`UDT_CTL_TRANSMIT_CLOCK_SELECT];
  assign reloadMode = baudMode | ~ctrl_r[`UDT_CTL_CPRL];
  assign upDownMode = reloadMode & down_count_enable_r;
  assign dirHigh = pinLevel[1];
  assign dirFall = pinFall[1];
  assign countUp = ~upDownMode | dirHigh;
  assign srcTick = counterSel ? pinFall[0] : divTick;
  assign step = runOn & srcTick;
  assign countWord = {count_high_byte_r, count_low_byte_r};
  assign reloadWord = {reload_high_byte_r, reload_low_byte_r};

  // ----------------------------------------------------------------
  // Count next state
  // ----------------------------------------------------------------
  wire lowCarry;
  wire lowBorrow;
  wire upWrap;
  wire downWrap;
  wire wrap;
  wire extReload;

  assign lowCarry = count_low_byte_r == `UDT_BYTE_MAX;
  assign lowBorrow = count_low_byte_r == `UDT_RST_BYTE;
  assign upWrap = step & countUp & (countWord == `UDT_WORD_MAX);
  assign downWrap = step & ~countUp & (countWord == reloadWord);
  assign wrap = upWrap | downWrap;
  // External reload on direction pin only outside up/down and baud use
  assign extReload = dirFall & ctrl_r[`UDT_CTL_EXEN] & reloadMode &
                     ~upDownMode & ~baudMode;

  reg [7:0] lowNxt;
  reg [7:0] highNxt;

  always @* begin
    lowNxt = count_low_byte_r;
    highNxt = count_high_byte_r;
    if (upWrap) begin
      if (reloadMode) begin
        lowNxt = reload_low_byte_r;
        highNxt = reload_high_byte_r;
      end else begin
        lowNxt = `UDT_RST_BYTE;
        highNxt = `UDT_RST_BYTE;
      end
    end else if (downWrap) begin
      lowNxt = `UDT_BYTE_MAX;
      highNxt = `UDT_BYTE_MAX;
    end else if (extReload) begin
      lowNxt = reload_low_byte_r;
      highNxt = reload_high_byte_r;
    end else if (step & countUp) begin
      lowNxt = count_low_byte_r + 8'h01;
      if (lowCarry) begin
        highNxt = count_high_byte_r + 8'h01;
      end
    end else if (step) begin
      lowNxt = count_low_byte_r - 8'h01;
      if (lowBorrow) begin
        highNxt = count_high_byte_r - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  wire req;
  wire wrReq;
  wire selCtrl;
  wire selMode;
  wire selCount;
  wire selReload;
  wire selStat;
  wire selMask;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrReq = req & wb_we_i;
  assign selCtrl = wb_adr_i == `UDT_OFS_CTRL;
  assign selMode = wb_adr_i == `UDT_OFS_MODE;
  assign selCount = wb_adr_i == `UDT_OFS_COUNT;
  assign selReload = wb_adr_i == `UDT_OFS_RELOAD;
  assign selStat = wb_adr_i == `UDT_OFS_STAT;
  assign selMask = wb_adr_i == `UDT_OFS_MASK;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  wire ovfSet;
  wire extEvt;
  wire extToggle;
  wire ctrlWr;
  wire statWr;

  assign ovfSet = wrap & ~baudMode;
  assign extToggle = wrap & upDownMode;
  assign extEvt = extReload;
  assign ctrlWr = wrReq & selCtrl & wb_sel_i[0];
  assign statWr = wrReq & selStat & wb_sel_i[0];

  reg extNxt;

  always @* begin
    extNxt = ctrl_r[`UDT_CTL_EXT];
    if (ctrlWr) begin
      extNxt = wb_dat_i[`UDT_CTL_EXT];
    end
    // Hardware change wins over a software write in the same cycle
    if (extToggle) begin
      extNxt = ~ctrl_r[`UDT_CTL_EXT];
    end else if (extEvt) begin
      extNxt = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      count_low_byte_r <= `UDT_RST_BYTE;
      count_high_byte_r <= `UDT_RST_BYTE;
      reload_low_byte_r <= `UDT_RST_BYTE;
      reload_high_byte_r <= `UDT_RST_BYTE;
      ctrl_r <= `UDT_RST_BYTE;
      down_count_enable_r <= 1'b0;
      stat_r <= `UDT_RST_ST;
      mask_r <= `UDT_RST_ST;
    end else begin
      count_low_byte_r <= lowNxt;
      count_high_byte_r <= highNxt;
      // Software load of the count takes priority over a step
      if (wrReq & selCount) begin
        if (wb_sel_i[0]) begin
          count_low_byte_r <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          count_high_byte_r <= wb_dat_i[15:8];
        end
      end
      if (wrReq & selReload) begin
        if (wb_sel_i[0]) begin
          reload_low_byte_r <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          reload_high_byte_r <= wb_dat_i[15:8];
        end
      end
      if (ctrlWr) begin
        ctrl_r[5:0] <= wb_dat_i[5:0];
      end
      ctrl_r[`UDT_CTL_EXT] <= extNxt;
      ctrl_r[`UDT_CTL_OVF] <= stat_r[`UDT_ST_OVF];
      if (wrReq & selMode & wb_sel_i[0]) begin
        down_count_enable_r <= wb_dat_i[`UDT_MOD_DOWN_COUNT_ENABLE];
      end
      if (wrReq & selMask & wb_sel_i[0]) begin
        mask_r <= wb_dat_i[`UDT_ST_W-1:0];
      end
      // Write one clears; a same-cycle set wins
      stat_r <= (stat_r & ~({`UDT_ST_W{statWr}} & wb_dat_i[`UDT_ST_W-1:0]))
                | {extEvt, ovfSet};
    end
  end

  // ----------------------------------------------------------------
  // Read mux, acknowledge and interrupt
  // ----------------------------------------------------------------
  reg [31:0] rdNxt;

  always @* begin
    rdNxt = 32'h0000_0000;
    if (selCtrl) begin
      rdNxt[7:0] = {stat_r[`UDT_ST_OVF], ctrl_r[6:0]};
    end else if (selMode) begin
      rdNxt[`UDT_MOD_DOWN_COUNT_ENABLE] = down_count_enable_r;
    end else if (selCount) begin
      rdNxt[15:0] = countWord;
      rdNxt[`UDT_CNT_EXT] = ctrl_r[`UDT_CTL_EXT];
    end else if (selReload) begin
      rdNxt[15:0] = reloadWord;
    end else if (selStat) begin
      rdNxt[`UDT_ST_W-1:0] = stat_r;
    end else if (selMask) begin
      rdNxt[`UDT_ST_W-1:0] = mask_r;
    end
  end

  always @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      irq_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
      if (req & ~wb_we_i) begin
        wb_dat_o <= rdNxt;
      end
      // Ext status only sets outside up/down mode, so it never fires there
      irq_o <= |(stat_r & mask_r);
    end
  end

endmodule
`default_nettype wire

// ===== testbench/udt_pin_model.sv
// Far-side model driving the external count and direction pins
`timescale 1ns/10ps
`default_nettype none
module udt_pin_model (
  input wire logic clk_sys, // System clock
  output var logic countPin, // Count input, idles high
  output var logic dirPin // Direction level
);
  initial begin
    countPin = 1'b1;
    dirPin = 1'b1;
  end
  // Low lasts gap cycles and high between pulses gap plus one; gap must stay at one or more
  task automatic pulse(input int n, input int gap);
    repeat (n) begin
      @(posedge clk_sys);
      countPin <= 1'b0;
      repeat (gap) @(posedge clk_sys);
      countPin <= 1'b1;
      repeat (gap) @(posedge clk_sys);
    end
  endtask
  task automatic setDir(input logic v);
    @(posedge clk_sys);
    dirPin <= v;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ===== testbench/udt_timer_bench.sv
// Self-checking bench for the up/down reload timer
`timescale 1ns/10ps
`default_nettype none
`include "udt_consts.vh"
module udt_timer_bench;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic cntPin;
  logic dirPin;
  logic [31:0] d0;
  logic [31:0] d1;
  logic [31:0] mc [3] = '{32'h07, 32'h17, 32'h27};
  logic [31:0] mcnt [3] = '{32'h0, 32'h1234, 32'h1234};
  logic [31:0] mst [3] = '{32'h1, 32'h0, 32'h0};
  int fails = 0;
  int comparisons = 0;
  int i;

  always #5 clk_sys = ~clk_sys;

  udt_timer udt_timer_i (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .count_input_pin(cntPin), .direction_pin(dirPin), .irq_o(irq));
  udt_pin_model udt_pin_model_i (.clk_sys(clk_sys), .countPin(cntPin), .dirPin(dirPin));

  // ----------------------------------------
  // Bus and checking tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v,
    output logic [31:0] r);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    do @(posedge clk_sys); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] r;
    bus(1'b1, a, v, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic irqIs(input logic e);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Generous limit: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    finish_test();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (i = 0; i <= 24; i += 4) rd(i[7:0], 32'h0);
    wr(8'h18, 32'hFFFF);
    rd(8'h18, 32'h0);
    wr(`UDT_OFS_RELOAD, 32'h1234);
    rd(`UDT_OFS_RELOAD, 32'h1234);
    wr(`UDT_OFS_CTRL, 32'h02);
    wr(`UDT_OFS_COUNT, 32'h00FF);
    udt_pin_model_i.pulse(2, 3);
    rd(`UDT_OFS_COUNT, 32'h00FF);
    wr(`UDT_OFS_CTRL, 32'h06);
    udt_pin_model_i.pulse(1, 3);
    rd(`UDT_OFS_COUNT, 32'h0100);
    wr(`UDT_OFS_MASK, 32'h1);
    wr(`UDT_OFS_COUNT, 32'hFFFE);
    udt_pin_model_i.pulse(2, 7);
    rd(`UDT_OFS_COUNT, 32'h1234);
    rd(`UDT_OFS_STAT, 32'h1);
    rd(`UDT_OFS_CTRL, 32'h86);
    irqIs(1'b1);
    wr(`UDT_OFS_MASK, 32'h0);
    irqIs(1'b0);
    wr(`UDT_OFS_MASK, 32'h1);
    irqIs(1'b1);
    wr(`UDT_OFS_STAT, 32'h1);
    irqIs(1'b0);
    for (i = 0; i < 3; i++) begin
      wr(`UDT_OFS_CTRL, mc[i]);
      wr(`UDT_OFS_COUNT, 32'hFFFF);
      udt_pin_model_i.pulse(1, 3);
      rd(`UDT_OFS_COUNT, mcnt[i]);
      rd(`UDT_OFS_STAT, mst[i]);
      wr(`UDT_OFS_STAT, 32'h3);
    end
    wr(`UDT_OFS_CTRL, 32'h06);
    udt_pin_model_i.setDir(1'b0);
    wr(`UDT_OFS_COUNT, 32'h0010);
    udt_pin_model_i.pulse(1, 3);
    rd(`UDT_OFS_COUNT, 32'h0011);
    wr(`UDT_OFS_MODE, 32'h1);
    rd(`UDT_OFS_MODE, 32'h1);
    wr(`UDT_OFS_MASK, 32'h2);
    wr(`UDT_OFS_COUNT, 32'h1235);
    udt_pin_model_i.pulse(1, 3);
    rd(`UDT_OFS_COUNT, 32'h1234);
    udt_pin_model_i.pulse(1, 3);
    rd(`UDT_OFS_COUNT, 32'h1FFFF);
    rd(`UDT_OFS_STAT, 32'h1);
    rd(`UDT_OFS_CTRL, 32'hC6);
    irqIs(1'b0);
    wr(`UDT_OFS_STAT, 32'h1);
    udt_pin_model_i.setDir(1'b1);
    udt_pin_model_i.pulse(1, 3);
    rd(`UDT_OFS_COUNT, 32'h01234);
    rd(`UDT_OFS_STAT, 32'h1);
    // Outside up/down mode a direction pin fall reloads and raises status bit 1
    wr(`UDT_OFS_MODE, 32'h0);
    wr(`UDT_OFS_STAT, 32'h3);
    wr(`UDT_OFS_CTRL, 32'h0E);
    wr(`UDT_OFS_COUNT, 32'h0042);
    udt_pin_model_i.setDir(1'b0);
    rd(`UDT_OFS_COUNT, 32'h11234);
    rd(`UDT_OFS_STAT, 32'h2);
    irqIs(1'b1);
    udt_pin_model_i.setDir(1'b1);
    // Reads spaced 240 cycles apart must see exactly 20 prescaler ticks
    wr(`UDT_OFS_MODE, 32'h0);
    wr(`UDT_OFS_CTRL, 32'h04);
    bus(1'b0, `UDT_OFS_COUNT, 32'h0, d0);
    repeat (237) @(posedge clk_sys);
    bus(1'b0, `UDT_OFS_COUNT, 32'h0, d1);
    chk(d1 - d0, 32'h14);
    finish_test();
  end
endmodule
`default_nettype wire

// ===== testbench/udt_timer_sva.sv
// Checker for the timer's bus handshake, read data and interrupt ports
`timescale 1ns/10ps
`default_nettype none
module udt_timer_sva (
  input wire logic clk_sys, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic irq_o // Interrupt
);
  // ----------------------------------------
  // Helper terms
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic take;
  logic rdTake;
  logic clrWr;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rdTake = take && !wb_we_i;
  // Only a status or mask write may pull the interrupt down
  assign clrWr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
    (wb_adr_i == 8'h10 || wb_adr_i == 8'h14);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_ack_next_cycle: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_data_on_read: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read");
  a_unmapped_zero: assert property (rdTake && wb_adr_i == 8'h18 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_mode_one_bit: assert property (rdTake && wb_adr_i == 8'h04 |=>
    wb_dat_o[31:1] == 31'h0)
    else $error("mode register shows extra bits");
  a_count_17_bits: assert property (rdTake && wb_adr_i == 8'h08 |=>
    wb_dat_o[31:17] == 15'h0)
    else $error("count read wider than 17 bits");
  a_irq_drop_cause: assert property ($fell(irq_o) |-> $past(clrWr) || $past(clrWr, 2))
    else $error("interrupt dropped without a clear");
endmodule
bind udt_timer udt_timer_sva udt_timer_sva_i (.clk_sys(clk_sys), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
`default_nettype wire
